// ==== core/slsm_pkg.sv ====
// How it works
// - format 10: 9-bit samples get a trailing zero, four 10-bit words per lane, 8/4/2 lanes.
// - format 10: channel c even samples on lane 2c, odd samples on lane 2c+1.
// - format 11: 9-bit sample plus three zeros, five words per lane, then tail nibble.
// - format 11: dual/single only; channel A lanes 0-3 by sample mod 4, B lanes 4-7.
// - format 12: 8-bit samples, sample k on lane k, second channel on lanes 4-7.
// - format 13: trailing zero pad; lane k carries samples k, k+4, k+8, k+12.
// - format 13: dual/single only; second channel same interleave on lanes 4-7.
package slsm_pkg;
  localparam int LANES = 8;
  localparam int FRAME_BITS = 64;
  localparam int SAMPLE_W = 9;
  localparam int CHANNELS = 4;
  localparam int MAX_SAMPLES = 20;
  localparam int IN_W = CHANNELS * MAX_SAMPLES * SAMPLE_W;
  localparam logic [3:0] FMT_10 = 4'ha;
  localparam logic [3:0] FMT_11 = 4'hb;
  localparam logic [3:0] FMT_12 = 4'hc;
  localparam logic [3:0] FMT_13 = 4'hd;
  localparam logic [3:0] TAIL_NIBBLE = 4'h0;
  localparam logic [1:0] VAR_SINGLE = 2'h0;
  localparam logic [1:0] VAR_DUAL = 2'h1;
  localparam logic [1:0] VAR_QUAD = 2'h2;
  localparam int FIFO_DEPTH = 8;
  localparam int LANES_PER_CH10 = 2;
  localparam int LANES_PER_CH = 4;
  localparam int WORDS10 = 4;
  localparam int WORDS11 = 5;
  localparam int WORD10_W = 10;
  localparam int WORD11_W = 12;
  localparam int OCTET_W = 8;
  localparam int TAIL_W = 4;
endpackage

// ==== core/slsm_fifo.sv ====
`timescale 1ns/1ns
module slsm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i, // clock
  input wire logic arst_n_i, // async reset
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // not full
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic out_valid_o, // not empty
  input wire logic out_ready_i, // read accept
  output logic [WIDTH-1:0] out_data_o // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic wr, rd;
  always_comb begin
    wr = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
    rd = out_valid_o && out_ready_i;
    wp_nxt = wr ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = rd ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (wr) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
endmodule // slsm_fifo

// ==== core/slsm_mapper.sv ====
`timescale 1ns/1ns
module slsm_mapper (
  input wire logic ref_clk_i, // sample clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [3:0] link_format_select_i, // link format 10..13
  input wire logic [1:0] variant_i, // 0 single, 1 dual, 2 quad
  input wire logic frame_valid_i, // frame of samples offered
  output logic frame_ready_o, // buffer has room
  input wire logic [slsm_pkg::IN_W-1:0] samples_i, // ch c sample n at (c*20+n)*9
  output logic [slsm_pkg::LANES*slsm_pkg::FRAME_BITS-1:0] lane_data_o, // lane l at l*64
  output logic [slsm_pkg::LANES-1:0] lane_en_o, // lanes in use
  output logic lane_valid_o, // lane_data_o holds a frame
  input wire logic lane_ready_i, // link takes frame
  output logic fmt_error_o // unsupported format/variant combination
);
  localparam int LW = slsm_pkg::LANES * slsm_pkg::FRAME_BITS;
  localparam int FW = LW + slsm_pkg::LANES;
  localparam int SW = slsm_pkg::SAMPLE_W;
  localparam int FB = slsm_pkg::FRAME_BITS;

  ////////////////////////////////////////////////////////////////////////////////
  // combinational mapping of one frame to lane words, msb-first on the lane
  wire logic [LW-1:0] map_data;
  wire logic [slsm_pkg::LANES-1:0] map_en;
  logic map_ok;
  logic fmt_known;
  logic fmt_narrow;
  logic quad_sel;
  logic dual_sel;
  logic single_sel;

  function automatic logic [SW-1:0] smp(input logic [slsm_pkg::IN_W-1:0] s,
                                        input int ch, input int n);
    smp = s[(ch*slsm_pkg::MAX_SAMPLES+n)*SW +: SW];
  endfunction

  // formats 11 to 13 carry at most two channels, so a quad request is refused
  // outright rather than mapping only half of the channels
  always_comb begin
    quad_sel = (variant_i == slsm_pkg::VAR_QUAD);
    dual_sel = (variant_i == slsm_pkg::VAR_DUAL);
    single_sel = (variant_i == slsm_pkg::VAR_SINGLE);
    fmt_known = 1'b0;
    fmt_narrow = 1'b0;
    if (link_format_select_i == slsm_pkg::FMT_10) begin
      fmt_known = 1'b1;
    end else if (link_format_select_i == slsm_pkg::FMT_11) begin
      fmt_known = 1'b1;
      fmt_narrow = 1'b1;
    end else if (link_format_select_i == slsm_pkg::FMT_12) begin
      fmt_known = 1'b1;
      fmt_narrow = 1'b1;
    end else if (link_format_select_i == slsm_pkg::FMT_13) begin
      fmt_known = 1'b1;
      fmt_narrow = 1'b1;
    end
    map_ok = fmt_known && !(fmt_narrow && quad_sel);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-lane word builders; every lane builds all four layouts and a mux picks
  // one, which costs area but keeps each layout readable on its own
  for (genvar l = 0; l < slsm_pkg::LANES; l++) begin : g_lane
    // which channel and which slot of it this lane serves
    localparam int CH2 = l / slsm_pkg::LANES_PER_CH10;
    localparam int ODD = l % slsm_pkg::LANES_PER_CH10;
    localparam int CH4 = l / slsm_pkg::LANES_PER_CH;
    localparam int POS = l % slsm_pkg::LANES_PER_CH;
    logic [FB-1:0] word10;
    logic [FB-1:0] word11;
    logic [FB-1:0] word12;
    logic [FB-1:0] word13;
    logic [FB-1:0] word_sel;
    logic [SW-1:0] s12;
    logic en_sel;

    // lane 2c carries even samples of channel c, lane 2c+1 the odd ones
    always_comb begin
      word10 = '0;
      for (int w = 0; w < slsm_pkg::WORDS10; w++) begin
        word10[FB-1 - w*slsm_pkg::WORD10_W -: slsm_pkg::WORD10_W] =
          {smp(samples_i, CH2, slsm_pkg::LANES_PER_CH10*w + ODD), 1'b0};
      end
    end

    // five 12-bit words then the tail nibble fill the eight octets
    always_comb begin
      word11 = '0;
      for (int w = 0; w < slsm_pkg::WORDS11; w++) begin
        word11[FB-1 - w*slsm_pkg::WORD11_W -: slsm_pkg::WORD11_W] =
          {smp(samples_i, CH4, slsm_pkg::LANES_PER_CH*w + POS), 3'h0};
      end
      word11[slsm_pkg::TAIL_W-1:0] = slsm_pkg::TAIL_NIBBLE;
    end

    // the 8-bit layout keeps the upper eight bits; the lsb is dropped
    always_comb begin
      s12 = smp(samples_i, CH4, POS);
      word12 = '0;
      word12[FB-1 -: slsm_pkg::OCTET_W] = s12[SW-1 -: slsm_pkg::OCTET_W];
    end

    // sample n goes to lane n mod 4, so lane k sees k, k+4, k+8, k+12
    always_comb begin
      word13 = '0;
      for (int w = 0; w < slsm_pkg::WORDS10; w++) begin
        word13[FB-1 - w*slsm_pkg::WORD10_W -: slsm_pkg::WORD10_W] =
          {smp(samples_i, CH4, POS + slsm_pkg::LANES_PER_CH*w), 1'b0};
      end
    end

    // unknown formats leave the lane dark
    always_comb begin
      word_sel = '0;
      en_sel = 1'b0;
      if (link_format_select_i == slsm_pkg::FMT_10) begin
        word_sel = word10;
        en_sel = (CH2 == 0) || (CH2 == 1 && !single_sel) || quad_sel;
      end else if (link_format_select_i == slsm_pkg::FMT_11) begin
        word_sel = word11;
        en_sel = (CH4 == 0) || dual_sel;
      end else if (link_format_select_i == slsm_pkg::FMT_12) begin
        word_sel = word12;
        en_sel = (CH4 == 0) || dual_sel;
      end else if (link_format_select_i == slsm_pkg::FMT_13) begin
        word_sel = word13;
        en_sel = (CH4 == 0) || dual_sel;
      end
    end

    // a refused frame lights no lane
    assign map_data[l*FB +: FB] = word_sel;
    assign map_en[l] = en_sel && map_ok;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame buffer; refused frames never enter, so the link never sees junk
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic push;
  logic pop;

  // a frame offered while full is lost; the source must watch frame_ready_o

  assign push = frame_valid_i && map_ok;

  slsm_fifo #(
    .WIDTH(FW),
    .DEPTH(slsm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({map_en, map_data}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // output register stage: one-deep skid so every output is a flop
  logic out_valid_r;
  logic out_valid_nxt;
  logic [LW-1:0] out_data_r;
  logic [LW-1:0] out_data_nxt;
  logic [slsm_pkg::LANES-1:0] out_en_r;
  logic [slsm_pkg::LANES-1:0] out_en_nxt;
  logic ready_r;
  logic ready_nxt;
  logic err_r;
  logic err_nxt;

  // pop only when the output register is empty or is emptied at this edge
  assign pop = fifo_out_valid && (!out_valid_r || lane_ready_i);

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    out_en_nxt = out_en_r;
    if (pop) begin
      out_valid_nxt = 1'b1;
      out_data_nxt = fifo_out_data[LW-1:0];
      out_en_nxt = fifo_out_data[FW-1:LW];
    end else if (lane_ready_i) begin
      out_valid_nxt = 1'b0;
    end
  end

  // ready lags one cycle; the fifo itself drops writes when full
  always_comb begin
    ready_nxt = fifo_in_ready;
    err_nxt = !map_ok;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
      out_en_r <= '0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
      out_en_r <= out_en_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
      err_r <= err_nxt;
    end
  end

  // every output is a plain register copy

  assign lane_valid_o = out_valid_r;
  assign lane_data_o = out_data_r;
  assign lane_en_o = out_en_r;
  assign frame_ready_o = ready_r;
  assign fmt_error_o = err_r;
endmodule // slsm_mapper

// ==== verif/slsm_mapper_props.sv ====
`timescale 1ns/1ns
module slsm_mapper_props (
  input wire logic ref_clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic [3:0] link_format_select_i, // format
  input wire logic [1:0] variant_i, // variant
  input wire logic [511:0] lane_data_o, // lanes
  input wire logic [7:0] lane_en_o, // enables
  input wire logic lane_valid_o, // frame out
  input wire logic fmt_error_o // refusal
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // format held steady while a frame stands
  wire f10 = link_format_select_i == 4'ha;
  wire f13 = link_format_select_i == 4'hd;
  AST_PAD10: assert property (lane_valid_o && f10 |-> lane_data_o[23:0] == 24'h0 && !lane_data_o[54])
    else $error("pad bits set");
  AST_EN10: assert property (lane_valid_o && f10 && variant_i == 2'h2 |-> lane_en_o == 8'hff)
    else $error("quad lanes off");
  AST_TAIL11: assert property (lane_valid_o && link_format_select_i == 4'hb |-> lane_data_o[3:0] == 4'h0 && lane_data_o[54:52] == 3'h0)
    else $error("tail or fill set");
  AST_QUAD11: assert property (link_format_select_i == 4'hb && variant_i == 2'h2 |=> fmt_error_o)
    else $error("quad not refused");
  AST_EN12: assert property (lane_valid_o && link_format_select_i == 4'hc && variant_i == 2'h1 |-> lane_en_o == 8'hff)
    else $error("dual lanes off");
  AST_PAD13: assert property (lane_valid_o && f13 |-> lane_data_o[23:0] == 24'h0 && !lane_data_o[118])
    else $error("pad bits set");
  AST_EN13: assert property (lane_valid_o && f13 && variant_i == 2'h0 |-> lane_en_o == 8'h0f)
    else $error("single lanes wrong");
endmodule // slsm_mapper_props

// ==== verif/slsm_sink.sv ====
`timescale 1ns/1ns
module slsm_sink (
  input wire logic ref_clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic lane_valid_i, // frame offered
  input wire logic stall_i, // hold off
  output logic lane_ready_o, // frame taken
  output int taken_o // frames accepted
);
  assign lane_ready_o = !stall_i;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i) taken_o <= 0;
    else if (lane_valid_i && lane_ready_o) taken_o <= taken_o + 1;
endmodule // slsm_sink

// ==== verif/slsm_mapper_tb_top.sv ====
`timescale 1ns/1ns
module slsm_mapper_tb_top;
  logic clk = 0, rst_n = 0, fv = 0, stall = 0;
  logic [3:0] fmt = 4'ha;
  logic [1:0] vr = 2'h0;
  logic [slsm_pkg::IN_W-1:0] smp;
  logic [511:0] ld;
  logic [7:0] en;
  logic fr, lv, lr, fe;
  int err_count = 0, checks_done = 0, taken;
  always #50 clk = ~clk;
  slsm_mapper dut_u (.ref_clk_i(clk), .arst_n_i(rst_n), .link_format_select_i(fmt),
    .variant_i(vr), .frame_valid_i(fv), .frame_ready_o(fr), .samples_i(smp),
    .lane_data_o(ld), .lane_en_o(en), .lane_valid_o(lv), .lane_ready_i(lr), .fmt_error_o(fe));
  slsm_sink snk_u (.ref_clk_i(clk), .arst_n_i(rst_n), .lane_valid_i(lv), .stall_i(stall),
    .lane_ready_o(lr), .taken_o(taken));
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [8:0] s(int c, int n);
    return 9'(256 + c * 32 + n);
  endfunction
  function automatic logic [63:0] exp_lane(logic [3:0] f, int l);
    logic [63:0] r;
    r = '0;
    for (int w = 0; w < 5; w++)
      if (f == 4'ha && w < 4) r[63-10*w -: 10] = {s(l/2, 2*w+l%2), 1'b0};
      else if (f == 4'hb) r[63-12*w -: 12] = {s(l/4, 4*w+l%4), 3'h0};
      else if (f == 4'hd && w < 4) r[63-10*w -: 10] = {s(l/4, l%4+4*w), 1'b0};
    if (f == 4'hc) r[63:56] = 8'(s(l/4, l%4) >> 1);
    return r;
  endfunction
  task automatic offer(logic [3:0] f, logic [1:0] v);
    @(posedge clk);
    fmt <= f;
    vr <= v;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    @(negedge clk);
  endtask
  task automatic map_case(logic [3:0] f, logic [1:0] v, logic [7:0] e);
    offer(f, v);
    for (int i = 0; i < 20 && lv !== 1'b1; i++) @(negedge clk);
    if (lv !== 1'b1) begin
      err_count++;
      print_verdict();
    end
    chk("lane_en", 64'(en), 64'(e));
    // only the top octet is defined for 8-bit frames
    for (int l = 0; l < 8; l++)
      chk("lane", ld[l*64 +: 64] & (f == 4'hc ? 64'hff00_0000_0000_0000 : '1), exp_lane(f, l));
    repeat (3) @(posedge clk);
  endtask
  task automatic refuse_case(logic [3:0] f, logic [1:0] v);
    offer(f, v);
    chk("fmt_error", 64'(fe), 64'h1);
    repeat (3) @(negedge clk);
    chk("dropped", 64'(lv), 64'h0);
  endtask
  // link stalls; fifo plus output stage hold nine frames
  task automatic fill_case();
    int t0;
    t0 = taken;
    @(posedge clk);
    fmt <= 4'hd;
    vr <= 2'h1;
    stall <= 1'b1;
    fv <= 1'b1;
    repeat (14) @(posedge clk);
    fv <= 1'b0;
    stall <= 1'b0;
    @(negedge clk);
    chk("full", 64'(fr), 64'h0);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk("drained", 64'(taken - t0), 64'(slsm_pkg::FIFO_DEPTH + 1));
  endtask
  initial begin
    for (int c = 0; c < 4; c++)
      for (int n = 0; n < 20; n++) smp[(c*20+n)*9 +: 9] = s(c, n);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    map_case(4'ha, 2'h0, 8'h03);
    map_case(4'ha, 2'h1, 8'h0f);
    map_case(4'ha, 2'h2, 8'hff);
    map_case(4'hb, 2'h0, 8'h0f);
    map_case(4'hb, 2'h1, 8'hff);
    map_case(4'hc, 2'h1, 8'hff);
    map_case(4'hd, 2'h0, 8'h0f);
    map_case(4'hd, 2'h1, 8'hff);
    refuse_case(4'hb, 2'h2);
    refuse_case(4'hd, 2'h2);
    refuse_case(4'hc, 2'h2);
    refuse_case(4'h9, 2'h0);
    fill_case();
    print_verdict();
  end
endmodule // slsm_mapper_tb_top
bind slsm_mapper slsm_mapper_props chk_u (.*);
